/* File: hw/irc_pkg.sv */
// Package: register map, field positions, reset values and counts for the IR carrier timer
package irc_pkg;

  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned CNT_W      = 9;

  typedef logic [ADDR_W-1:0] irc_addr_t;
  typedef logic [DATA_W-1:0] irc_data_t;
  typedef logic [CNT_W-1:0]  irc_cnt_t;

  // Register offsets in data memory
  localparam irc_addr_t OFF_BURST_COUNT_LOW        = 8'h18;
  localparam irc_addr_t OFF_BURST_CONTROL          = 8'h19;
  localparam irc_addr_t OFF_CARRIER_LOW_PERIOD_LO  = 8'h1a;
  localparam irc_addr_t OFF_CARRIER_LOW_PERIOD_HI  = 8'h1b;
  localparam irc_addr_t OFF_CARRIER_HIGH_PERIOD_LO = 8'h1c;
  localparam irc_addr_t OFF_CARRIER_HIGH_PERIOD_HI = 8'h1d;

  // Field positions
  localparam int unsigned BIT_BURST_COUNT_BIT8      = 0;
  localparam int unsigned BIT_BURST_OUTPUT_ENABLE   = 1;
  localparam int unsigned BIT_BURST_END_FLAG        = 7;
  localparam int unsigned BIT_PERIOD_BIT8           = 0;
  localparam int unsigned BIT_CARRIER_DISABLE       = 1;

  // Values after reset
  localparam irc_data_t RST_BURST_COUNT_LOW   = 8'h00;
  localparam logic      RST_BURST_COUNT_BIT8  = 1'b0;
  localparam logic      RST_BURST_OUTPUT_EN   = 1'b0;
  localparam logic      RST_BURST_END_FLAG    = 1'b1;
  localparam irc_cnt_t  RST_PERIOD            = 9'h000;
  localparam logic      RST_CARRIER_DISABLE   = 1'b1;
  localparam irc_data_t RST_READ_DATA         = 8'h00;

  // Burst step length in system clocks
  localparam int unsigned BURST_STEP_CLOCKS = 64;
  localparam int unsigned PRESCALE_W        = $clog2(BURST_STEP_CLOCKS);
  localparam logic [PRESCALE_W-1:0] PRESCALE_LAST = PRESCALE_W'(BURST_STEP_CLOCKS - 1);
  localparam logic [PRESCALE_W-1:0] PRESCALE_ZERO = '0;
  localparam irc_cnt_t CNT_ZERO = 9'h000;
  localparam irc_cnt_t CNT_ONE  = 9'h001;

  // Carrier phase, one-hot
  typedef enum logic [1:0] {
    PH_LOW  = 2'b01,
    PH_HIGH = 2'b10
  } irc_phase_t;

endpackage : irc_pkg

/* File: hw/irc_car_if.sv */
// Interface: link between the burst timer and the carrier generator
interface irc_car_if;
  import irc_pkg::*;

  logic     run;
  irc_cnt_t period_low;
  irc_cnt_t period_high;
  logic     high;

  modport ctl (output run, output period_low, output period_high, input high);
  modport gen (input run, input period_low, input period_high, output high);
endinterface : irc_car_if

/* File: hw/irc_carrier_gen.sv */
// Carrier generator: 9-bit counter alternating low and high phases
module irc_carrier_gen (
  input  wire logic clk,
  input  wire logic arst_n,
  irc_car_if.gen    car
);
  import irc_pkg::*;

  irc_phase_t phase;
  irc_phase_t next_phase;
  irc_cnt_t   cnt;
  irc_cnt_t   next_cnt;

  always_comb begin
    next_phase = phase;
    next_cnt   = cnt;
    unique case (phase)
      PH_LOW: begin
        if (!car.run) begin
          next_cnt = CNT_ZERO;
        end else if (cnt == car.period_low) begin
          next_cnt   = CNT_ZERO;
          next_phase = PH_HIGH;
        end else begin
          next_cnt = cnt + CNT_ONE;
        end
      end
      PH_HIGH: begin
        // A high phase always completes, even after the burst ends
        if (cnt == car.period_high) begin
          next_cnt   = CNT_ZERO;
          next_phase = PH_LOW;
        end else begin
          next_cnt = cnt + CNT_ONE;
        end
      end
      default: begin
        next_cnt   = CNT_ZERO;
        next_phase = PH_LOW;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      phase <= PH_LOW;
      cnt   <= CNT_ZERO;
    end else begin
      phase <= next_phase;
      cnt   <= next_cnt;
    end
  end

  assign car.high = (phase == PH_HIGH);

endmodule : irc_carrier_gen

/* File: hw/irc_timer.sv */
// Top: IR burst timer, carrier registers and output pin control
module irc_timer #(
  parameter bit OPEN_DRAIN = 1'b0
) (
  input  wire logic               clk,
  input  wire logic               arst_n,
  input  wire irc_pkg::irc_addr_t mem_addr,
  input  wire logic               mem_wr,
  input  wire irc_pkg::irc_data_t mem_wdata,
  input  wire logic               mem_rd,
  output      irc_pkg::irc_data_t mem_rdata,
  output      logic               ir_pin_out,
  output      logic               ir_pin_oe
);
  import irc_pkg::*;

  function automatic logic hit(input irc_addr_t addr, input irc_addr_t off);
    hit = (addr == off);
  endfunction : hit

  irc_car_if car ();

  irc_carrier_gen u_gen (
    .clk    (clk),
    .arst_n (arst_n),
    .car    (car.gen)
  );

  // Registers
  irc_data_t                count_low;
  logic                     count_bit8;
  logic                     out_en;
  logic                     end_flag;
  irc_cnt_t                 down_cnt;
  logic                     running;
  logic [PRESCALE_W-1:0]    prescale;
  irc_cnt_t                 period_low;
  irc_cnt_t                 period_high;
  logic                     carrier_disable;

  irc_data_t                next_count_low;
  logic                     next_count_bit8;
  logic                     next_out_en;
  logic                     next_end_flag;
  irc_cnt_t                 next_down_cnt;
  logic                     next_running;
  logic [PRESCALE_W-1:0]    next_prescale;
  irc_cnt_t                 next_period_low;
  irc_cnt_t                 next_period_high;
  logic                     next_carrier_disable;

  logic wr_low;
  logic wr_ctrl;
  logic step;
  logic expire;

  assign wr_low  = mem_wr && hit(mem_addr, OFF_BURST_COUNT_LOW);
  assign wr_ctrl = mem_wr && hit(mem_addr, OFF_BURST_CONTROL);
  assign step    = running && (prescale == PRESCALE_LAST);
  assign expire  = step && (down_cnt == CNT_ZERO);

  // Burst timer next state
  always_comb begin
    next_count_low  = count_low;
    next_count_bit8 = count_bit8;
    next_out_en     = out_en;
    next_down_cnt   = down_cnt;
    next_running    = running;
    next_prescale   = running ? prescale + 1'b1 : PRESCALE_ZERO;
    next_end_flag   = end_flag;
    if (wr_low) begin
      next_count_low = mem_wdata;
    end
    if (step) begin
      if (down_cnt == CNT_ZERO) begin
        next_running = 1'b0;
      end else begin
        next_down_cnt = down_cnt - CNT_ONE;
      end
    end
    if (wr_ctrl) begin
      next_count_bit8 = mem_wdata[BIT_BURST_COUNT_BIT8];
      next_out_en     = mem_wdata[BIT_BURST_OUTPUT_ENABLE];
      next_down_cnt   = {mem_wdata[BIT_BURST_COUNT_BIT8], count_low};
      next_running    = mem_wdata[BIT_BURST_OUTPUT_ENABLE];
      next_prescale   = PRESCALE_ZERO;
      next_end_flag   = 1'b0;
    end
    if (expire) begin
      next_end_flag = 1'b1;
    end
  end

  // Carrier registers next state
  always_comb begin
    next_period_low      = period_low;
    next_period_high     = period_high;
    next_carrier_disable = carrier_disable;
    if (mem_wr) begin
      if (hit(mem_addr, OFF_CARRIER_LOW_PERIOD_LO)) begin
        next_period_low[7:0] = mem_wdata;
      end
      if (hit(mem_addr, OFF_CARRIER_LOW_PERIOD_HI)) begin
        next_period_low[8] = mem_wdata[BIT_PERIOD_BIT8];
      end
      if (hit(mem_addr, OFF_CARRIER_HIGH_PERIOD_LO)) begin
        next_period_high[7:0] = mem_wdata;
      end
      if (hit(mem_addr, OFF_CARRIER_HIGH_PERIOD_HI)) begin
        next_period_high[8]  = mem_wdata[BIT_PERIOD_BIT8];
        next_carrier_disable = mem_wdata[BIT_CARRIER_DISABLE];
      end
    end
  end

  // Read data and pin next values
  irc_data_t next_rdata;
  logic      next_pin_out;
  logic      next_pin_oe;
  logic      drive_high;

  always_comb begin
    next_rdata = mem_rdata;
    if (mem_rd) begin
      next_rdata = RST_READ_DATA;
      if (hit(mem_addr, OFF_BURST_COUNT_LOW)) begin
        next_rdata = count_low;
      end
      if (hit(mem_addr, OFF_BURST_CONTROL)) begin
        next_rdata[BIT_BURST_COUNT_BIT8]    = count_bit8;
        next_rdata[BIT_BURST_OUTPUT_ENABLE] = out_en;
        next_rdata[BIT_BURST_END_FLAG]      = end_flag;
      end
      if (hit(mem_addr, OFF_CARRIER_LOW_PERIOD_LO)) begin
        next_rdata = period_low[7:0];
      end
      if (hit(mem_addr, OFF_CARRIER_LOW_PERIOD_HI)) begin
        next_rdata[BIT_PERIOD_BIT8] = period_low[8];
      end
      if (hit(mem_addr, OFF_CARRIER_HIGH_PERIOD_LO)) begin
        next_rdata = period_high[7:0];
      end
      if (hit(mem_addr, OFF_CARRIER_HIGH_PERIOD_HI)) begin
        next_rdata[BIT_PERIOD_BIT8]     = period_high[8];
        next_rdata[BIT_CARRIER_DISABLE] = carrier_disable;
      end
    end
  end

  // Carrier runs only while the burst is gated out
  assign car.run         = out_en && running && !carrier_disable;
  assign car.period_low  = period_low;
  assign car.period_high = period_high;

  always_comb begin
    if (!out_en) begin
      drive_high = 1'b0;
    end else if (carrier_disable) begin
      drive_high = 1'b1;
    end else begin
      drive_high = car.high;
    end
    if (OPEN_DRAIN) begin
      next_pin_out = 1'b0;
      next_pin_oe  = drive_high;
    end else begin
      next_pin_out = drive_high;
      next_pin_oe  = 1'b1;
    end
  end

  // Burst timer registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count_low  <= RST_BURST_COUNT_LOW;
      count_bit8 <= RST_BURST_COUNT_BIT8;
      out_en     <= RST_BURST_OUTPUT_EN;
      end_flag   <= RST_BURST_END_FLAG;
      down_cnt   <= CNT_ZERO;
      running    <= 1'b0;
      prescale   <= PRESCALE_ZERO;
    end else begin
      count_low  <= next_count_low;
      count_bit8 <= next_count_bit8;
      out_en     <= next_out_en;
      end_flag   <= next_end_flag;
      down_cnt   <= next_down_cnt;
      running    <= next_running;
      prescale   <= next_prescale;
    end
  end

  // Carrier period registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      period_low      <= RST_PERIOD;
      period_high     <= RST_PERIOD;
      carrier_disable <= RST_CARRIER_DISABLE;
    end else begin
      period_low      <= next_period_low;
      period_high     <= next_period_high;
      carrier_disable <= next_carrier_disable;
    end
  end

  // Read data and pin registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mem_rdata  <= RST_READ_DATA;
      ir_pin_out <= 1'b0;
      ir_pin_oe  <= ~OPEN_DRAIN;
    end else begin
      mem_rdata  <= next_rdata;
      ir_pin_out <= next_pin_out;
      ir_pin_oe  <= next_pin_oe;
    end
  end

endmodule : irc_timer

/* File: tb/irc_timer_checker.sv */
// Checker: port-level assertions for the IR carrier timer
module irc_timer_checker import irc_pkg::*; #(
  parameter bit OPEN_DRAIN = 1'b0
) (
  input wire logic               clk,
  input wire logic               arst_n,
  input wire irc_pkg::irc_addr_t mem_addr,
  input wire logic               mem_wr,
  input wire irc_pkg::irc_data_t mem_wdata,
  input wire logic               mem_rd,
  input wire irc_pkg::irc_data_t mem_rdata,
  input wire logic               ir_pin_out,
  input wire logic               ir_pin_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  wire active = OPEN_DRAIN ? ir_pin_oe : ir_pin_out;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence ctrl_wr_rd;
    mem_wr && mem_addr == OFF_BURST_CONTROL ##2 mem_rd && mem_addr == OFF_BURST_CONTROL;
  endsequence
  chk_rdata_hold: assert property (!mem_rd |=> $stable(mem_rdata))
    else $error("read data changed without a read");
  chk_unmapped_read: assert property (mem_rd && (mem_addr < 8'h18 || mem_addr > 8'h1d)
    |=> mem_rdata == 8'h00) else $error("unmapped read not zero");
  chk_ctrl_unused: assert property (mem_rd && mem_addr == OFF_BURST_CONTROL
    |=> mem_rdata[6:2] == 5'h00) else $error("control unused bits not zero");
  chk_upper_unused: assert property (mem_rd && (mem_addr == OFF_CARRIER_LOW_PERIOD_HI
    || mem_addr == OFF_CARRIER_HIGH_PERIOD_HI) |=> mem_rdata[7:2] == 6'h00)
    else $error("period upper unused bits not zero");
  chk_low_bit9: assert property (mem_rd && mem_addr == OFF_CARRIER_LOW_PERIOD_HI
    |=> !mem_rdata[1]) else $error("low period bit 9 not zero");
  chk_ctrl_readback: assert property (ctrl_wr_rd |=>
    mem_rdata[1:0] == $past(mem_wdata[1:0], 3) && !mem_rdata[7])
    else $error("control readback or end flag wrong");
  chk_pin_mode: assert property (OPEN_DRAIN ? !ir_pin_out : ir_pin_oe)
    else $error("pin drive mode wrong");
  chk_stop_low: assert property (mem_wr && mem_addr == OFF_BURST_CONTROL
    && !mem_wdata[1] |-> ##[1:3] !active) else $error("pin active after stop");
  cover property (mem_wr && mem_addr == OFF_BURST_CONTROL && mem_wdata[1]);
  cover property ($fell(active));
  cover property (ctrl_wr_rd);
endmodule : irc_timer_checker

/* File: tb/irc_ir_emitter.sv */
// Partner: IR emitter on the pin, reports when it is lit
module irc_ir_emitter #(
  parameter bit OPEN_DRAIN = 1'b0
) (
  input  wire logic clk,
  input  wire logic pin_out,
  input  wire logic pin_oe,
  output      logic lit
);
  timeunit 1ns;
  timeprecision 1ns;
  logic last = 1'b0;
  // Open drain floats up through the diode; an undriven push-pull line shows junk
  wire level = pin_oe ? pin_out : (OPEN_DRAIN ? 1'b1 : ~last);
  always @(posedge clk) last <= level;
  assign lit = OPEN_DRAIN ? !level : level;
endmodule : irc_ir_emitter

/* File: tb/testbench.sv */
// Testbench: register, burst and carrier scenarios for the IR carrier timer
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import irc_pkg::*;
  logic      clk = 1'b0, arst_n = 1'b0, mem_wr = 1'b0, mem_rd = 1'b0;
  irc_addr_t mem_addr = '0;
  irc_data_t mem_wdata = '0, mem_rdata;
  logic      pp_out, pp_oe, od_out, od_oe, lit_pp, lit_od;
  int        errors = 0, checks_done = 0, hrun = 0, lrun = 0, hq[$], lq[$];
  int        cyc = 0, first_lit = 0, last_lit = 0;
  bit        seen = 0;
  logic [31:0] seed = 32'h0000_0004;
  always #10 clk = ~clk;
  irc_timer #(.OPEN_DRAIN(1'b0)) irc_timer_inst (.clk(clk), .arst_n(arst_n),
    .mem_addr(mem_addr), .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rd(mem_rd),
    .mem_rdata(mem_rdata), .ir_pin_out(pp_out), .ir_pin_oe(pp_oe));
  irc_timer #(.OPEN_DRAIN(1'b1)) irc_timer_od_inst (.clk(clk), .arst_n(arst_n),
    .mem_addr(mem_addr), .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rd(mem_rd),
    .mem_rdata(), .ir_pin_out(od_out), .ir_pin_oe(od_oe));
  irc_ir_emitter #(.OPEN_DRAIN(1'b0)) irc_ir_emitter_inst (.clk(clk), .pin_out(pp_out),
    .pin_oe(pp_oe), .lit(lit_pp));
  irc_ir_emitter #(.OPEN_DRAIN(1'b1)) irc_ir_emitter_od_inst (.clk(clk), .pin_out(od_out),
    .pin_oe(od_oe), .lit(lit_od));
  function logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  task summarize();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : summarize
  task check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task wr(input irc_addr_t a, input irc_data_t d);
    @(posedge clk);
    mem_addr <= a; mem_wdata <= d; mem_wr <= 1'b1;
    @(posedge clk);
    mem_wr <= 1'b0;
  endtask : wr
  task rd(input irc_addr_t a, input irc_data_t exp);
    @(posedge clk);
    mem_addr <= a; mem_rd <= 1'b1;
    @(posedge clk);
    mem_rd <= 1'b0;
    @(posedge clk);
    #1 check(mem_rdata, exp);
  endtask : rd
  task burst(input irc_cnt_t n);
    #1 hq.delete(); lq.delete(); seen = 0;
    first_lit = 0;
    wr(OFF_BURST_COUNT_LOW, n[7:0]);
    wr(OFF_BURST_CONTROL, {6'h00, 1'b1, n[8]});
    rd(OFF_BURST_CONTROL, {6'h00, 1'b1, n[8]});
    repeat ((int'(n) + 1) * 64 + 40) @(posedge clk);
    rd(OFF_BURST_CONTROL, {6'h20, 1'b1, n[8]});
  endtask : burst
  // Lit and dark run lengths seen by the emitter
  always @(posedge clk) begin
    cyc++;
    if (lit_pp === 1'b1) begin
      if (first_lit == 0) first_lit = cyc;
      last_lit = cyc;
      if (seen && lrun > 0) lq.push_back(lrun);
      lrun = 0; hrun++;
    end else begin
      if (hrun > 0) begin hq.push_back(hrun); seen = 1; end
      hrun = 0; lrun++;
    end
  end
  always @(negedge clk) check({pp_oe, od_out, lit_od}, {1'b1, 1'b0, lit_pp});
  initial begin
    #1_000_000 errors++;
    summarize();
  end
  initial begin
    int n, i, lo, hi;
    irc_data_t rv[6];
    rv = '{8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h02};
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    for (i = 0; i < 6; i++) rd(irc_addr_t'(OFF_BURST_COUNT_LOW + i), rv[i]);
    rd(8'h20, 8'h00);
    wr(8'h20, 8'hff);
    rd(OFF_BURST_COUNT_LOW, 8'h00);
    wr(OFF_CARRIER_LOW_PERIOD_HI, 8'hff);
    rd(OFF_CARRIER_LOW_PERIOD_HI, 8'h01);
    wr(OFF_CARRIER_HIGH_PERIOD_HI, 8'hff);
    rd(OFF_CARRIER_HIGH_PERIOD_HI, 8'h03);
    wr(OFF_CARRIER_LOW_PERIOD_HI, 8'h00);
    // Carrier on with 2-clock phases, so bursts show as pulse trains
    wr(OFF_CARRIER_HIGH_PERIOD_HI, 8'h00);
    wr(OFF_CARRIER_LOW_PERIOD_LO, 8'h01);
    wr(OFF_CARRIER_HIGH_PERIOD_LO, 8'h01);
    for (i = 0; i < 3; i++) begin
      n = (i == 0) ? 0 : (i == 1) ? int'(xs() % 8) : 256;
      burst(irc_cnt_t'(n));
      // One pulse per 4 clocks; lit span skips the first low phase
      check(hq.size(), (n + 1) * BURST_STEP_CLOCKS / 4);
      check(last_lit - first_lit + 1, (n + 1) * BURST_STEP_CLOCKS - 2);
    end
    wr(OFF_BURST_COUNT_LOW, 8'h05);
    wr(OFF_BURST_CONTROL, 8'h02);
    repeat (100) @(posedge clk);
    wr(OFF_BURST_CONTROL, 8'h00);
    repeat (10) @(posedge clk);
    #1 hq.delete();
    first_lit = 0;
    wr(OFF_BURST_CONTROL, 8'h02);
    repeat (6 * 64 + 40) @(posedge clk);
    check(hq.size(), 6 * BURST_STEP_CLOCKS / 4);
    check(last_lit - first_lit + 1, 6 * BURST_STEP_CLOCKS - 2);
    lo = 1 + int'(xs() % 6);
    hi = 1 + int'(xs() % 6);
    wr(OFF_BURST_CONTROL, 8'h00);
    wr(OFF_CARRIER_LOW_PERIOD_LO, irc_data_t'(lo));
    wr(OFF_CARRIER_HIGH_PERIOD_LO, irc_data_t'(hi));
    wr(OFF_CARRIER_HIGH_PERIOD_HI, 8'h00);
    burst(9'h001);
    check(hq.size() > 0, 1);
    foreach (hq[k]) check(hq[k], hi + 1);
    foreach (lq[k]) check(lq[k], lo + 1);
    // Count is zero, so the pin is low and the disable bit may be written
    wr(OFF_CARRIER_HIGH_PERIOD_HI, 8'h02);
    repeat (3) @(posedge clk);
    #1 check(pp_out, 1'b1);
    wr(OFF_BURST_CONTROL, 8'h00);
    repeat (3) @(posedge clk);
    #1 check(pp_out, 1'b0);
    summarize();
  end
endmodule : testbench
bind irc_timer irc_timer_checker #(.OPEN_DRAIN(OPEN_DRAIN)) irc_timer_checker_inst (
  .clk(clk), .arst_n(arst_n), .mem_addr(mem_addr), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
  .mem_rd(mem_rd), .mem_rdata(mem_rdata), .ir_pin_out(ir_pin_out), .ir_pin_oe(ir_pin_oe));
